// ==== design/lomsel_pkg.sv ====
// Package with register map, field values, timing and carrier types of the loop output mode selector
// Operation
// R1: Stop halts PID computation and drives preset output, ignoring output limits.
// R2: No output rate-of-change limit applies while stopped.
// R3: Stop kind 0: heat equals preset, chill 0%; kind 2: chill equals chill preset.
// R4: Stop on/off kinds: 0% if preset at most 0.0%, else 100.0%; kind 1 chill 0%.
// R5: Run to Stop steps output to preset at once, no ramp.
// R6: Single PID Stop to Run keeps output, clamped if beyond limits.
// R7: PID kinds in Automatic restart computation from output just after the switch.
// R8: Kinds 0 and 1 in Manual copy preset into manual value at Stop to Run.
// R9: On/off kinds in Automatic follow process value versus setpoint after Stop to Run.
// R10: Heating/chill PID steps both outputs to 0.0%; negative dead band uses setting.
// R11: Heating/chill kinds in Manual copy computed outputs into both manual values.
// R12: Cascade behaves as Automatic on Stop to Run for every kind.
// R13: Manual output acts only in Run; Stop drives preset even in Manual.
// R14: Automatic to Manual while running leaves output unchanged.
// R15: Manual drives manual values clamped to limits, no rate limit.
// R16: On/off kinds in Manual output only 100% or 0%; separate heat and chill.
// R17: Heating/chill PID in Manual applies manual values to heat or chill output.
// R18: Readable auto_manual_flag, 0 Automatic and 1 Manual.
// R19: PID kinds Manual to Automatic restart from output just after the switch.
// R20: On/off kinds after Manual to Automatic follow process value versus setpoint.
// R21: Software selects cascade controller mode before writing 2 to mode.
// R22: Presets are signed 0.1% steps from -50 to 1050, reset 0.
// R23: Mode and parameters are sampled and applied once per control period.
package lomsel_pkg;
  localparam int IDX_W = 10;
  localparam logic [9:0] IDX_RUN_STOP = 10'h079;
  localparam logic [9:0] IDX_LOOP_MODE = 10'h07a;
  localparam logic [9:0] IDX_KIND = 10'h07b;
  localparam logic [9:0] IDX_UPPER = 10'h07c;
  localparam logic [9:0] IDX_LOWER = 10'h07d;
  localparam logic [9:0] IDX_DEAD_BAND = 10'h07e;
  localparam logic [9:0] IDX_NEGDB_HEAT = 10'h07f;
  localparam logic [9:0] IDX_STATUS = 10'h080;
  localparam logic [9:0] IDX_MAN_HEAT = 10'h086;
  localparam logic [9:0] IDX_MAN_CHILL = 10'h087;
  localparam logic [3:0][9:0] IDX_PRESET = {10'h115, 10'h101, 10'h0ed, 10'h0d9};
  localparam logic [3:0][9:0] IDX_CHILL_PRESET = {10'h116, 10'h102, 10'h0ee, 10'h0da};
  localparam logic signed [15:0] OUT_FULL = 16'sh03e8;
  localparam logic signed [15:0] OUT_ZERO = 16'sh0000;
  localparam logic signed [15:0] ON_THRESH = 16'sh0001;
  localparam logic signed [15:0] PRESET_MIN = -16'sh0032;
  localparam logic signed [15:0] PRESET_MAX = 16'sh041a;
  localparam logic signed [15:0] RST_PRESET = 16'sh0000;
  localparam logic signed [15:0] RST_UPPER = 16'sh03e8;
  localparam logic signed [15:0] RST_LOWER = 16'sh0000;
  localparam logic signed [15:0] RST_MANUAL = 16'sh0000;
  localparam logic signed [15:0] RST_DEAD_BAND = 16'sh0000;
  localparam logic RST_RUN_STOP = 1'b0;
  localparam int STATUS_FLAG_BIT = 0;
  localparam int STATUS_RUN_BIT = 1;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;
  localparam int CLK_PERIOD_NS = 20;
  localparam int CTRL_PERIOD_US = 200;
  localparam int CTRL_PERIOD_CYCLES = CTRL_PERIOD_US * 1000 / CLK_PERIOD_NS;

  typedef enum logic [1:0] {MODE_AUTO, MODE_MANUAL, MODE_CASCADE} lomsel_mode_type;
  typedef enum logic [1:0] {KIND_PID, KIND_ONOFF, KIND_HC_PID, KIND_HC_ONOFF} lomsel_kind_type;

  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hready;
  } lomsel_ahb_in_type;

  typedef struct packed {
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
  } lomsel_ahb_out_type;

  typedef struct packed {
    logic signed [15:0] pid_heat;
    logic signed [15:0] pid_chill;
    logic onoff_heat;
    logic onoff_chill;
    logic [1:0] group;
  } lomsel_ctrl_in_type;

  typedef struct packed {
    logic signed [15:0] heating_output;
    logic signed [15:0] chill_output;
    logic track_load;
    logic auto_manual_flag;
    logic running;
    logic period_tick;
  } lomsel_loop_out_type;
endpackage

// ==== design/lomsel_clamp.sv ====
// Signed clamp of a value into a lower and upper limit
`timescale 1ns/1ps
module lomsel_clamp #(
  parameter int W = 16
) (
  input wire logic signed [W-1:0] value,
  input wire logic signed [W-1:0] lower,
  input wire logic signed [W-1:0] upper,
  output logic signed [W-1:0] result
);
  // Lower limit wins if software sets the limits crossed
  always_comb
  begin
    result = value;
    if (value > upper)
    begin
      result = upper;
    end
    if (result < lower)
    begin
      result = lower;
    end
  end
endmodule

// ==== design/lomsel_top.sv ====
// Loop output mode selector: AHB-Lite registers, run/stop and auto/manual output selection
`timescale 1ns/1ps
module lomsel_top #(
  parameter int PERIOD_CYCLES = lomsel_pkg::CTRL_PERIOD_CYCLES
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire lomsel_pkg::lomsel_ahb_in_type ahb_in,
  output lomsel_pkg::lomsel_ahb_out_type ahb_out,
  input wire lomsel_pkg::lomsel_ctrl_in_type ctrl_in,
  output lomsel_pkg::lomsel_loop_out_type loop_out
);
  typedef struct packed {
    logic run_stop;
    lomsel_pkg::lomsel_mode_type mode;
    lomsel_pkg::lomsel_kind_type kind;
    logic signed [15:0] upper;
    logic signed [15:0] lower;
    logic signed [15:0] dead_band;
    logic signed [15:0] negdb_heat;
    logic signed [15:0] man_heat;
    logic signed [15:0] man_chill;
    logic [3:0][15:0] preset;
    logic [3:0][15:0] chill_preset;
    logic [31:0] period_cnt;
    logic tick;
    logic run_prev;
    lomsel_pkg::lomsel_mode_type mode_prev;
    logic signed [15:0] heat;
    logic signed [15:0] chill;
    logic track;
    logic flag;
    logic wr_pend;
    logic [9:0] wr_idx;
    logic [31:0] rdata;
  } lomsel_state_type;

  lomsel_state_type st_reg;
  lomsel_state_type st_next;
  logic signed [15:0] clamp_heat_in;
  logic signed [15:0] clamp_chill_in;
  logic signed [15:0] clamp_heat;
  logic signed [15:0] clamp_chill;
  logic signed [15:0] preset_sel;
  logic signed [15:0] chill_preset_sel;
  logic is_manual;

  assign preset_sel = signed'(st_reg.preset[ctrl_in.group]);
  assign chill_preset_sel = signed'(st_reg.chill_preset[ctrl_in.group]);
  assign is_manual = (st_reg.mode == lomsel_pkg::MODE_MANUAL);
  // Held heating output after Stop (chill has none), manual value in Manual, computed value otherwise
  assign clamp_heat_in = !st_reg.run_prev ? st_reg.heat : (is_manual ? st_reg.man_heat : ctrl_in.pid_heat);
  assign clamp_chill_in = is_manual ? st_reg.man_chill : ctrl_in.pid_chill;

  lomsel_clamp #(.W(16)) u_clamp_heat (
    .value(clamp_heat_in),
    .lower(st_reg.lower),
    .upper(st_reg.upper),
    .result(clamp_heat)
  );

  lomsel_clamp #(.W(16)) u_clamp_chill (
    .value(clamp_chill_in),
    .lower(st_reg.lower),
    .upper(st_reg.upper),
    .result(clamp_chill)
  );

  function automatic logic signed [15:0] onoff(input logic signed [15:0] v);
    return (v >= lomsel_pkg::ON_THRESH) ? lomsel_pkg::OUT_FULL : lomsel_pkg::OUT_ZERO;
  endfunction

  function automatic logic signed [15:0] bit_level(input logic b);
    return b ? lomsel_pkg::OUT_FULL : lomsel_pkg::OUT_ZERO;
  endfunction

  function automatic logic signed [15:0] sat_preset(input logic signed [15:0] v);
    logic signed [15:0] r;
    r = v;
    if (v < lomsel_pkg::PRESET_MIN)
    begin
      r = lomsel_pkg::PRESET_MIN;
    end
    else if (v > lomsel_pkg::PRESET_MAX)
    begin
      r = lomsel_pkg::PRESET_MAX;
    end
    return r;
  endfunction

  function automatic logic [31:0] read_reg(input lomsel_state_type s, input logic [9:0] idx);
    logic [15:0] d;
    d = 16'h0000;
    case (idx)
      lomsel_pkg::IDX_RUN_STOP: d = {15'h0000, s.run_stop};
      lomsel_pkg::IDX_LOOP_MODE: d = {14'h0000, s.mode};
      lomsel_pkg::IDX_KIND: d = {14'h0000, s.kind};
      lomsel_pkg::IDX_UPPER: d = s.upper;
      lomsel_pkg::IDX_LOWER: d = s.lower;
      lomsel_pkg::IDX_DEAD_BAND: d = s.dead_band;
      lomsel_pkg::IDX_NEGDB_HEAT: d = s.negdb_heat;
      lomsel_pkg::IDX_STATUS: d = {14'h0000, s.run_prev, s.flag};
      lomsel_pkg::IDX_MAN_HEAT: d = s.man_heat;
      lomsel_pkg::IDX_MAN_CHILL: d = s.man_chill;
      default: d = 16'h0000;
    endcase
    for (int g = 0; g < 4; g++)
    begin
      if (idx == lomsel_pkg::IDX_PRESET[g])
      begin
        d = s.preset[g];
      end
      if (idx == lomsel_pkg::IDX_CHILL_PRESET[g])
      begin
        d = s.chill_preset[g];
      end
    end
    return {16'h0000, d};
  endfunction

  always_comb
  begin
    logic signed [15:0] wd;
    logic [9:0] aidx;
    wd = signed'(ahb_in.hwdata[15:0]);
    aidx = ahb_in.haddr[11:2];
    st_next = st_reg;
    st_next.tick = 1'b0;
    st_next.track = 1'b0;
    // Control period divider
    if (st_reg.period_cnt >= 32'(PERIOD_CYCLES - 1))
    begin
      st_next.period_cnt = 32'h00000000;
      st_next.tick = 1'b1;
    end
    else
    begin
      st_next.period_cnt = st_reg.period_cnt + 32'h00000001;
    end
    // Write data phase
    if (st_reg.wr_pend)
    begin
      st_next.wr_pend = 1'b0;
      case (st_reg.wr_idx)
        lomsel_pkg::IDX_RUN_STOP: st_next.run_stop = wd[0];
        lomsel_pkg::IDX_LOOP_MODE: st_next.mode = lomsel_pkg::lomsel_mode_type'(wd[1:0]);
        lomsel_pkg::IDX_KIND: st_next.kind = lomsel_pkg::lomsel_kind_type'(wd[1:0]);
        lomsel_pkg::IDX_UPPER: st_next.upper = wd;
        lomsel_pkg::IDX_LOWER: st_next.lower = wd;
        lomsel_pkg::IDX_DEAD_BAND: st_next.dead_band = wd;
        lomsel_pkg::IDX_NEGDB_HEAT: st_next.negdb_heat = wd;
        lomsel_pkg::IDX_MAN_HEAT: st_next.man_heat = wd;
        lomsel_pkg::IDX_MAN_CHILL: st_next.man_chill = wd;
        default: st_next.wr_pend = 1'b0;
      endcase
      for (int g = 0; g < 4; g++)
      begin
        if (st_reg.wr_idx == lomsel_pkg::IDX_PRESET[g])
        begin
          st_next.preset[g] = sat_preset(wd); // R22
        end
        if (st_reg.wr_idx == lomsel_pkg::IDX_CHILL_PRESET[g])
        begin
          st_next.chill_preset[g] = sat_preset(wd); // R22
        end
      end
    end
    // Address phase; reads see a write landing in the same cycle
    if (ahb_in.hsel && ahb_in.hready && ahb_in.htrans == lomsel_pkg::HTRANS_NONSEQ)
    begin
      if (ahb_in.hwrite)
      begin
        st_next.wr_pend = 1'b1;
        st_next.wr_idx = aidx;
      end
      else
      begin
        st_next.rdata = read_reg(st_next, aidx);
      end
    end
    // Output selection once per period; hardware copies override a same-cycle software write
    if (st_reg.tick) // R23
    begin
      st_next.run_prev = st_reg.run_stop;
      st_next.mode_prev = st_reg.mode;
      st_next.flag = is_manual; // R18
      if (!st_reg.run_stop) // R1 R2 R5 R13
      begin
        unique case (st_reg.kind)
          lomsel_pkg::KIND_PID:
          begin
            st_next.heat = preset_sel; // R3
            st_next.chill = lomsel_pkg::OUT_ZERO;
          end
          lomsel_pkg::KIND_ONOFF:
          begin
            st_next.heat = onoff(preset_sel); // R4
            st_next.chill = lomsel_pkg::OUT_ZERO;
          end
          lomsel_pkg::KIND_HC_PID:
          begin
            st_next.heat = preset_sel; // R3
            st_next.chill = chill_preset_sel;
          end
          lomsel_pkg::KIND_HC_ONOFF:
          begin
            st_next.heat = onoff(preset_sel); // R4
            st_next.chill = onoff(chill_preset_sel);
          end
        endcase
      end
      else if (!st_reg.run_prev) // R12
      begin
        unique case (st_reg.kind)
          lomsel_pkg::KIND_PID:
          begin
            st_next.heat = clamp_heat; // R6
            st_next.chill = lomsel_pkg::OUT_ZERO;
            if (is_manual)
            begin
              st_next.man_heat = preset_sel; // R8
            end
            else
            begin
              st_next.track = 1'b1; // R7
            end
          end
          lomsel_pkg::KIND_ONOFF:
          begin
            st_next.chill = lomsel_pkg::OUT_ZERO;
            if (is_manual)
            begin
              st_next.man_heat = preset_sel; // R8
              st_next.heat = onoff(preset_sel);
            end
            else
            begin
              st_next.heat = bit_level(ctrl_in.onoff_heat); // R9
            end
          end
          lomsel_pkg::KIND_HC_PID:
          begin
            // Negative dead band: heating starts at its own setting
            st_next.heat = (st_reg.dead_band < 0) ? st_reg.negdb_heat : lomsel_pkg::OUT_ZERO; // R10
            st_next.chill = lomsel_pkg::OUT_ZERO; // R10
            if (is_manual)
            begin
              st_next.man_heat = (st_reg.dead_band < 0) ? st_reg.negdb_heat : lomsel_pkg::OUT_ZERO; // R11
              st_next.man_chill = lomsel_pkg::OUT_ZERO; // R11
            end
            else
            begin
              st_next.track = 1'b1; // R7
            end
          end
          lomsel_pkg::KIND_HC_ONOFF:
          begin
            st_next.heat = bit_level(ctrl_in.onoff_heat); // R9
            st_next.chill = bit_level(ctrl_in.onoff_chill);
            if (is_manual)
            begin
              st_next.man_heat = bit_level(ctrl_in.onoff_heat); // R11
              st_next.man_chill = bit_level(ctrl_in.onoff_chill); // R11
            end
          end
        endcase
      end
      else if (is_manual)
      begin
        if (st_reg.mode_prev != lomsel_pkg::MODE_MANUAL)
        begin
          // Output held; manual values take it over so the switch is bumpless
          st_next.man_heat = st_reg.heat; // R14
          st_next.man_chill = st_reg.chill; // R14
        end
        else
        begin
          unique case (st_reg.kind)
            lomsel_pkg::KIND_PID:
            begin
              st_next.heat = clamp_heat; // R15
              st_next.chill = lomsel_pkg::OUT_ZERO;
            end
            lomsel_pkg::KIND_ONOFF:
            begin
              st_next.heat = onoff(st_reg.man_heat); // R16
              st_next.chill = lomsel_pkg::OUT_ZERO;
            end
            lomsel_pkg::KIND_HC_PID:
            begin
              st_next.heat = clamp_heat; // R17
              st_next.chill = clamp_chill; // R15
            end
            lomsel_pkg::KIND_HC_ONOFF:
            begin
              st_next.heat = onoff(st_reg.man_heat); // R16
              st_next.chill = onoff(st_reg.man_chill); // R16
            end
          endcase
        end
      end
      else
      begin
        unique case (st_reg.kind)
          lomsel_pkg::KIND_PID, lomsel_pkg::KIND_HC_PID:
          begin
            if (st_reg.mode_prev == lomsel_pkg::MODE_MANUAL)
            begin
              st_next.track = 1'b1; // R19
            end
            else
            begin
              st_next.heat = clamp_heat;
              st_next.chill = (st_reg.kind == lomsel_pkg::KIND_PID) ? lomsel_pkg::OUT_ZERO : clamp_chill;
            end
          end
          lomsel_pkg::KIND_ONOFF:
          begin
            st_next.heat = bit_level(ctrl_in.onoff_heat); // R20
            st_next.chill = lomsel_pkg::OUT_ZERO;
          end
          lomsel_pkg::KIND_HC_ONOFF:
          begin
            st_next.heat = bit_level(ctrl_in.onoff_heat); // R20
            st_next.chill = bit_level(ctrl_in.onoff_chill); // R20
          end
        endcase
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_reg <= '0;
      st_reg.run_stop <= lomsel_pkg::RST_RUN_STOP;
      st_reg.mode <= lomsel_pkg::MODE_AUTO;
      st_reg.kind <= lomsel_pkg::KIND_PID;
      st_reg.upper <= lomsel_pkg::RST_UPPER;
      st_reg.lower <= lomsel_pkg::RST_LOWER;
      st_reg.dead_band <= lomsel_pkg::RST_DEAD_BAND;
      st_reg.man_heat <= lomsel_pkg::RST_MANUAL;
      st_reg.man_chill <= lomsel_pkg::RST_MANUAL;
      st_reg.preset <= {4{lomsel_pkg::RST_PRESET}};
      st_reg.chill_preset <= {4{lomsel_pkg::RST_PRESET}};
      st_reg.mode_prev <= lomsel_pkg::MODE_AUTO;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign ahb_out.hreadyout = 1'b1;
  assign ahb_out.hresp = lomsel_pkg::HRESP_OKAY;
  assign ahb_out.hrdata = st_reg.rdata;
  assign loop_out.heating_output = st_reg.heat;
  assign loop_out.chill_output = st_reg.chill;
  assign loop_out.track_load = st_reg.track;
  assign loop_out.auto_manual_flag = st_reg.flag;
  assign loop_out.running = st_reg.run_prev;
  assign loop_out.period_tick = st_reg.tick;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  sequence s_stop_tick;
    st_reg.tick && !st_reg.run_stop;
  endsequence

  sequence s_run_to_stop;
    st_reg.tick && st_reg.run_prev && !st_reg.run_stop;
  endsequence

  sequence s_manual_steady;
    st_reg.tick && st_reg.run_stop && st_reg.run_prev && is_manual && st_reg.mode_prev == lomsel_pkg::MODE_MANUAL;
  endsequence

  a_stop_heat_preset: assert property (s_stop_tick ##0 (st_reg.kind == lomsel_pkg::KIND_PID) |=> // R1
    st_reg.heat == $past(preset_sel)) else $error("stop output differs from preset");
  a_stop_chill_zero: assert property (s_stop_tick ##0 (st_reg.kind inside {lomsel_pkg::KIND_PID, lomsel_pkg::KIND_ONOFF}) // R3
    |=> st_reg.chill == 16'sh0000) else $error("stop chill output not zero");
  a_stop_onoff_full: assert property (s_stop_tick ##0 (st_reg.kind == lomsel_pkg::KIND_ONOFF) // R4
    |=> st_reg.heat == (($past(preset_sel) >= 16'sh0001) ? 16'sh03e8 : 16'sh0000)) else $error("stop on/off level wrong");
  a_run_stop_step: assert property (s_run_to_stop ##0 (st_reg.kind == lomsel_pkg::KIND_HC_PID) |=> // R5
    st_reg.heat == $past(preset_sel) && st_reg.chill == $past(chill_preset_sel)) else $error("run to stop not immediate");
  a_manual_clamped: assert property (s_manual_steady ##0 (st_reg.kind == lomsel_pkg::KIND_PID) // R15
    ##0 (st_reg.lower <= st_reg.upper) |=> st_reg.heat <= st_reg.upper && st_reg.heat >= st_reg.lower)
    else $error("manual output outside limits");
  a_manual_onoff_level: assert property (s_manual_steady ##0 // R16
    (st_reg.kind inside {lomsel_pkg::KIND_ONOFF, lomsel_pkg::KIND_HC_ONOFF}) |=>
    (st_reg.heat == 16'sh03e8 || st_reg.heat == 16'sh0000) && (st_reg.chill == 16'sh03e8 || st_reg.chill == 16'sh0000))
    else $error("manual on/off output not 0 or 100");
  a_auto_man_bumpless: assert property (st_reg.tick && st_reg.run_stop && st_reg.run_prev && is_manual && // R14
    st_reg.mode_prev == lomsel_pkg::MODE_AUTO |=> $stable(st_reg.heat) && st_reg.man_heat == st_reg.heat)
    else $error("auto to manual changed output");
  a_manual_copy_preset: assert property (st_reg.tick && st_reg.run_stop && !st_reg.run_prev && is_manual && // R8
    st_reg.kind == lomsel_pkg::KIND_PID |=> st_reg.man_heat == $past(preset_sel)) else $error("preset not copied");
  a_flag_follows: assert property (st_reg.tick |=> st_reg.flag == ($past(st_reg.mode) == lomsel_pkg::MODE_MANUAL)) // R18
    else $error("auto_manual_flag wrong");
  a_track_pulse: assert property (st_reg.tick && st_reg.run_stop && st_reg.run_prev && !is_manual && // R19
    st_reg.kind == lomsel_pkg::KIND_PID && st_reg.mode_prev == lomsel_pkg::MODE_MANUAL |=> st_reg.track ##1 !st_reg.track)
    else $error("no restart pulse after manual to auto");
  a_period_spacing: assert property (st_reg.tick |=> !st_reg.tick [*2]) else $error("period ticks too close"); // R23
  a_preset_range: assert property (signed'(st_reg.preset[0]) >= -16'sh0032 && signed'(st_reg.preset[0]) <= 16'sh041a) // R22
    else $error("preset out of range");
endmodule

// ==== dv/lomsel_tb.sv ====
// Self-checking testbench of the loop output mode selector
`timescale 1ns/1ps
module tb;
  logic core_clk;
  logic nrst;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  lomsel_pkg::lomsel_ahb_in_type ahb_in;
  lomsel_pkg::lomsel_ahb_out_type ahb_out;
  lomsel_pkg::lomsel_ctrl_in_type ctrl_in;
  lomsel_pkg::lomsel_loop_out_type loop_out;
  int n_fail;
  int num_checks;
  logic [31:0] rd;

  // The one slave's hreadyout is the bus hready
  assign ahb_in = {hsel, haddr, htrans, hwrite, hsize, hwdata, ahb_out.hreadyout};

  lomsel_top #(.PERIOD_CYCLES(16)) i_lomsel_top (.core_clk(core_clk), .nrst(nrst), .ahb_in(ahb_in),
    .ahb_out(ahb_out), .ctrl_in(ctrl_in), .loop_out(loop_out));

  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Bounded wait for hready high at a rising edge
  task automatic wait_ready();
    for (int i = 0; i < 50; i++)
    begin
      @(posedge core_clk);
      if (ahb_out.hreadyout === 1'b1)
        return;
    end
    n_fail++;
    tally_and_finish();
  endtask

  function automatic logic [31:0] byte_addr(input logic [9:0] idx);
    return {20'h0, idx, 2'b00};
  endfunction

  task automatic bus(input logic [9:0] idx, input logic wr, input logic [15:0] wdata);
    hsel <= 1'b1;
    haddr <= byte_addr(idx);
    htrans <= lomsel_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {16'h0, wdata};
    wait_ready();
    rd = ahb_out.hrdata;
  endtask

  task automatic reg_wr(input logic [9:0] idx, input logic [15:0] d);
    bus(idx, 1'b1, d);
  endtask

  task automatic reg_chk(input string what, input logic [9:0] idx, input logic [31:0] exp);
    bus(idx, 1'b0, 16'h0);
    chk(what, exp, rd);
  endtask

  // Returns at the edge after the one that applies a period decision, so outputs are settled
  task automatic wait_tick();
    for (int i = 0; i < 100; i++)
    begin
      @(posedge core_clk);
      if (loop_out.period_tick === 1'b1)
      begin
        @(posedge core_clk);
        return;
      end
    end
    n_fail++;
    tally_and_finish();
  endtask

  task automatic out_chk(input logic [15:0] heat, input logic [15:0] chill);
    chk("heating_output", {16'h0, heat}, {16'h0, loop_out.heating_output});
    chk("chill_output", {16'h0, chill}, {16'h0, loop_out.chill_output});
  endtask

  task automatic s_reset_values();
    reg_chk("run_stop", lomsel_pkg::IDX_RUN_STOP, 32'h0);
    chk("hresp", 32'h0, {31'h0, ahb_out.hresp});
    reg_chk("loop_mode", lomsel_pkg::IDX_LOOP_MODE, 32'h0);
    reg_chk("upper", lomsel_pkg::IDX_UPPER, 32'h3e8);
    reg_chk("chill_preset", lomsel_pkg::IDX_CHILL_PRESET[2], 32'h0);
    reg_chk("unmapped", 10'h3ff, 32'h0);
    reg_wr(lomsel_pkg::IDX_PRESET[0], 16'h07d0);
    reg_chk("preset_hi", lomsel_pkg::IDX_PRESET[0], 32'h41a);
    reg_wr(lomsel_pkg::IDX_PRESET[0], 16'hff9c);
    reg_chk("preset_lo", lomsel_pkg::IDX_PRESET[0], 32'hffce);
  endtask

  // Stop outputs for every regulation kind, preset beyond limits included
  task automatic s_stop_kinds();
    logic [15:0] tbl [4][4];
    tbl = '{'{16'h041a, 16'h01f4, 16'h041a, 16'h0000}, '{16'h0001, 16'h01f4, 16'h03e8, 16'h0000},
            '{16'hffce, 16'h02bc, 16'hffce, 16'h02bc}, '{16'h0000, 16'h0001, 16'h0000, 16'h03e8}};
    for (int k = 0; k < 4; k++)
    begin
      reg_wr(lomsel_pkg::IDX_KIND, 16'(k));
      reg_wr(lomsel_pkg::IDX_PRESET[0], tbl[k][0]);
      reg_wr(lomsel_pkg::IDX_CHILL_PRESET[0], tbl[k][1]);
      wait_tick();
      wait_tick();
      out_chk(tbl[k][2], tbl[k][3]);
    end
  endtask

  task automatic s_pid_run_manual();
    reg_wr(lomsel_pkg::IDX_KIND, 16'h0);
    reg_wr(lomsel_pkg::IDX_PRESET[0], 16'h041a);
    wait_tick();
    out_chk(16'h041a, 16'h0);
    ctrl_in.pid_heat <= 16'sd500;
    reg_wr(lomsel_pkg::IDX_RUN_STOP, 16'h1);
    wait_tick();
    out_chk(16'h03e8, 16'h0);
    chk("track_load", 32'h1, {31'h0, loop_out.track_load});
    wait_tick();
    out_chk(16'h01f4, 16'h0);
    ctrl_in.pid_heat <= 16'sd700;
    reg_wr(lomsel_pkg::IDX_LOOP_MODE, 16'h1);
    wait_tick();
    out_chk(16'h01f4, 16'h0);
    chk("auto_manual_flag", 32'h1, {31'h0, loop_out.auto_manual_flag});
    reg_chk("status", lomsel_pkg::IDX_STATUS, 32'h3);
    reg_wr(lomsel_pkg::IDX_MAN_HEAT, 16'h0410);
    wait_tick();
    out_chk(16'h03e8, 16'h0);
    reg_wr(lomsel_pkg::IDX_RUN_STOP, 16'h0);
    wait_tick();
    out_chk(16'h041a, 16'h0);
    reg_wr(lomsel_pkg::IDX_RUN_STOP, 16'h1);
    wait_tick();
    reg_chk("manual_heat", lomsel_pkg::IDX_MAN_HEAT, 32'h41a);
    out_chk(16'h03e8, 16'h0);
    reg_wr(lomsel_pkg::IDX_LOOP_MODE, 16'h0);
    wait_tick();
    out_chk(16'h03e8, 16'h0);
    chk("auto_manual_flag", 32'h0, {31'h0, loop_out.auto_manual_flag});
    wait_tick();
    out_chk(16'h02bc, 16'h0);
  endtask

  task automatic s_onoff_and_cascade();
    reg_wr(lomsel_pkg::IDX_RUN_STOP, 16'h0);
    reg_wr(lomsel_pkg::IDX_KIND, 16'h3);
    reg_wr(lomsel_pkg::IDX_PRESET[0], 16'h0);
    wait_tick();
    wait_tick();
    ctrl_in.onoff_heat <= 1'b1;
    reg_wr(lomsel_pkg::IDX_RUN_STOP, 16'h1);
    wait_tick();
    out_chk(16'h03e8, 16'h0);
    reg_wr(lomsel_pkg::IDX_LOOP_MODE, 16'h1);
    wait_tick();
    reg_wr(lomsel_pkg::IDX_MAN_HEAT, 16'h0);
    reg_wr(lomsel_pkg::IDX_MAN_CHILL, 16'h03e8);
    wait_tick();
    out_chk(16'h0, 16'h03e8);
    reg_wr(lomsel_pkg::IDX_LOOP_MODE, 16'h0);
    wait_tick();
    out_chk(16'h03e8, 16'h0);
    // Kind changes while running so the run to stop step is seen for heating/chill PID
    reg_wr(lomsel_pkg::IDX_KIND, 16'h2);
    reg_wr(lomsel_pkg::IDX_RUN_STOP, 16'h0);
    reg_wr(lomsel_pkg::IDX_LOOP_MODE, 16'h2);
    wait_tick();
    ctrl_in.pid_chill <= 16'sd300;
    reg_wr(lomsel_pkg::IDX_RUN_STOP, 16'h1);
    wait_tick();
    out_chk(16'h0, 16'h0);
    reg_wr(lomsel_pkg::IDX_LOOP_MODE, 16'h1);
    wait_tick();
    reg_wr(lomsel_pkg::IDX_MAN_HEAT, 16'h0384);
    reg_wr(lomsel_pkg::IDX_MAN_CHILL, 16'h00c8);
    wait_tick();
    out_chk(16'h0384, 16'h00c8);
    reg_wr(lomsel_pkg::IDX_DEAD_BAND, 16'hfff6);
    reg_wr(lomsel_pkg::IDX_NEGDB_HEAT, 16'h0064);
    reg_wr(lomsel_pkg::IDX_RUN_STOP, 16'h0);
    wait_tick();
    chk("running", 32'h0, {31'h0, loop_out.running});
    reg_wr(lomsel_pkg::IDX_RUN_STOP, 16'h1);
    wait_tick();
    out_chk(16'h0064, 16'h0);
    chk("running", 32'h1, {31'h0, loop_out.running});
    reg_chk("manual_heat", lomsel_pkg::IDX_MAN_HEAT, 32'h64);
    reg_chk("manual_chill", lomsel_pkg::IDX_MAN_CHILL, 32'h0);
  endtask

  initial
  begin
    n_fail = 0;
    num_checks = 0;
    nrst = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    ctrl_in = '0;
    repeat (6) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    s_reset_values();
    s_stop_kinds();
    s_pid_run_manual();
    s_onoff_and_cascade();
    tally_and_finish();
  end
endmodule
